// File: verilog/mbrg_pkg.sv
// Shared constants and types for the modem bit rate generator
`default_nettype none
package mbrg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FRAC_W = 4;
    localparam int unsigned DIV_W  = 16;
    localparam int unsigned FIFO_DEPTH = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DIV_LOW  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FRAC     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_TXDATA   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;

    // Reset values
    localparam logic [BYTE_W-1:0] DIV_HIGH_RST = 8'h1a;
    localparam logic [BYTE_W-1:0] DIV_LOW_RST  = 8'h0b;
    localparam logic [FRAC_W-1:0] FRAC_RST     = 4'h0;

    // Status bit positions
    localparam int unsigned ST_TX      = 0;
    localparam int unsigned ST_RX      = 1;
    localparam int unsigned ST_EMPTY   = 2;
    localparam int unsigned ST_FULL    = 3;
    localparam int unsigned ST_RESTART = 4;
    localparam int unsigned ST_BIT     = 5;
    localparam int unsigned ST_W       = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MBRG_OP_IDLE = 2'h0,
        MBRG_OP_TX   = 2'h1,
        MBRG_OP_RX   = 2'h2
    } mbrg_op_t;

    // Transmit engine, Gray coded along off, start, run
    typedef enum logic [1:0] {
        MBRG_ENG_OFF   = 2'h0,
        MBRG_ENG_START = 2'h1,
        MBRG_ENG_RUN   = 2'h3
    } mbrg_eng_t;

    // Control register layout, low bits first from op
    typedef struct packed {
        logic     shaping;
        logic     ook;
        logic     continuous;
        mbrg_op_t op;
    } mbrg_ctrl_t;

    localparam int unsigned CTRL_W = 5;
    localparam mbrg_ctrl_t CTRL_RST = '{shaping: 1'b0, ook: 1'b0,
                                        continuous: 1'b0, op: MBRG_OP_IDLE};

    // Modulator drive: synthesizer step, PA enable, current bit
    typedef struct packed {
        logic              pa_on;
        logic signed [2:0] step;
        logic              bit_val;
    } mbrg_mod_t;
endpackage : mbrg_pkg
`default_nettype wire

// File: verilog/mbrg_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`default_nettype none
module mbrg_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic                  empty,
    output logic                  full
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[PW-1:0]];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (push) mem[wr_ptr[PW-1:0]] <= in_data;
    end
endmodule : mbrg_fifo
`default_nettype wire

// File: verilog/mbrg_top.sv
// Bit rate generator and transmit data entry with AXI4-Lite registers
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`default_nettype none
//
// Contract
// - Continuous mode without shaping: data pin goes to modulator, no bit timing.
// - Continuous mode with shaping: drive bit clock, host sends bits in step.
// - Bit period is crystal period times divisor plus fraction over 16.
// - OOK selected: fraction ignored, integer divisor alone times bits.
// - Half-duplex: transmit and receive paths never active together.
// - All settings including divisor and fraction are writable and readable.
// - Transmit modulation steps the synthesizer division, optionally pre-filtered; with OOK the step is held at zero and only the PA is gated.
// - Each rising bit clock edge asks the host for the next transmit bit.
module mbrg_top #(
    parameter int unsigned FIFO_DEPTH = mbrg_pkg::FIFO_DEPTH
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [mbrg_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [mbrg_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [mbrg_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [mbrg_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          general_io_two,
    output logic                               bit_clock_out,
    output mbrg_pkg::mbrg_mod_t                mod_out,
    output logic                               tx_active,
    output logic                               rx_active
);
    localparam int unsigned BW = mbrg_pkg::BYTE_W;
    localparam int unsigned FW = mbrg_pkg::FRAC_W;
    localparam int unsigned DW = mbrg_pkg::DIV_W;

    function automatic logic signed [2:0] bit_level(input logic b);
        bit_level = b ? 3'sh1 : 3'sh7;
    endfunction : bit_level

    function automatic logic [FW:0] frac_add(input logic [FW-1:0] a, input logic [FW-1:0] f);
        frac_add = {1'b0, a} + {1'b0, f};
    endfunction : frac_add

    // Registers
    mbrg_pkg::mbrg_ctrl_t ctrl;
    logic [BW-1:0]        div_high;
    logic [BW-1:0]        div_low;
    logic [FW-1:0]        frac;
    logic                 restart_needed;

    // Bus state
    logic [mbrg_pkg::ADDR_W-1:0] wr_addr;
    logic [mbrg_pkg::DATA_W-1:0] wr_data;
    logic [3:0]                  wr_strb;

    // Bit engine state
    mbrg_pkg::mbrg_eng_t eng;
    logic                shaping_used;
    logic [DW-1:0]       cnt;
    logic [FW-1:0]       acc;
    logic                data_meta;
    logic                data_sync;
    logic                cur_bit;
    logic                prev_bit;
    logic [BW-1:0]       shreg;
    logic [3:0]          bits_left;

    // FIFO wiring
    logic [BW-1:0] fifo_out;
    logic          fifo_out_valid;
    logic          fifo_in_ready;
    logic          fifo_empty;
    logic          fifo_full;

    // Write path decode
    wire have_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire lane0       = wr_strb[0];
    wire wr_ctrl     = (wr_addr == mbrg_pkg::OFF_CTRL);
    wire wr_high     = (wr_addr == mbrg_pkg::OFF_DIV_HIGH);
    wire wr_low      = (wr_addr == mbrg_pkg::OFF_DIV_LOW);
    wire wr_frac     = (wr_addr == mbrg_pkg::OFF_FRAC);
    wire wr_tx       = (wr_addr == mbrg_pkg::OFF_TXDATA);
    wire wr_stat     = (wr_addr == mbrg_pkg::OFF_STATUS);
    wire wr_mapped   = wr_ctrl || wr_high || wr_low || wr_frac || wr_tx || wr_stat;
    // Back-pressure: a data write waits for room in the FIFO
    wire do_write    = have_write && !(wr_tx && lane0 && !fifo_in_ready);
    wire fifo_push   = do_write && wr_tx && lane0;
    localparam int unsigned CTRL_W_L = mbrg_pkg::CTRL_W;
    wire [CTRL_W_L-1:0] wr_ctrl_bits = wr_data[CTRL_W_L-1:0];
    wire mbrg_pkg::mbrg_ctrl_t new_ctrl = mbrg_pkg::mbrg_ctrl_t'(wr_ctrl_bits);

    // Read path decode
    wire [mbrg_pkg::ST_W-1:0] status = {cur_bit, restart_needed, fifo_full,
                                        fifo_empty, rx_active, tx_active};
    wire rd_ctrl  = (s_axi_araddr == mbrg_pkg::OFF_CTRL);
    wire rd_high  = (s_axi_araddr == mbrg_pkg::OFF_DIV_HIGH);
    wire rd_low   = (s_axi_araddr == mbrg_pkg::OFF_DIV_LOW);
    wire rd_frac  = (s_axi_araddr == mbrg_pkg::OFF_FRAC);
    wire rd_tx    = (s_axi_araddr == mbrg_pkg::OFF_TXDATA);
    wire rd_stat  = (s_axi_araddr == mbrg_pkg::OFF_STATUS);
    wire rd_mapped = rd_ctrl || rd_high || rd_low || rd_frac || rd_tx || rd_stat;
    wire [mbrg_pkg::DATA_W-1:0] rd_mux =
        rd_ctrl ? {{(mbrg_pkg::DATA_W-CTRL_W_L){1'b0}}, ctrl} :
        rd_high ? {{(mbrg_pkg::DATA_W-BW){1'b0}}, div_high} :
        rd_low  ? {{(mbrg_pkg::DATA_W-BW){1'b0}}, div_low} :
        rd_frac ? {{(mbrg_pkg::DATA_W-FW){1'b0}}, frac} :
        rd_stat ? {{(mbrg_pkg::DATA_W-mbrg_pkg::ST_W){1'b0}}, status} :
                  '0;

    // Bit timing decode
    wire [DW-1:0] div_raw  = {div_high, div_low};
    wire [DW-1:0] div_eff  = (div_raw == '0) ? DW'(1) : div_raw;
    // OOK forces the fraction to zero
    wire [FW-1:0] frac_eff = ctrl.ook ? '0 : frac;
    // Remainder accumulates; carry stretches one bit by a cycle
    wire [FW:0]   acc_sum  = frac_add(acc, frac_eff);
    // Reload for N plus fractional carry
    wire [DW-1:0] reload   = div_eff - DW'(1) + DW'(acc_sum[FW]);
    wire [DW-1:0] half_pt  = div_eff >> 1;
    wire          running  = tx_active || rx_active;
    wire          tick     = running && (cnt == '0);
    wire          tx_on    = (eng == mbrg_pkg::MBRG_ENG_RUN);
    wire          gauss    = ctrl.continuous && shaping_used;
    wire          async_tx = ctrl.continuous && !shaping_used;
    wire          need_byte = tx_on && tick && !ctrl.continuous && (bits_left == '0);
    wire          want_tx  = (ctrl.op == mbrg_pkg::MBRG_OP_TX);
    wire          set_restart = do_write && wr_ctrl && lane0 && (eng != mbrg_pkg::MBRG_ENG_OFF)
                              && (new_ctrl.shaping != ctrl.shaping);
    wire          clr_restart = (do_write && wr_stat && lane0 && wr_data[mbrg_pkg::ST_RESTART])
                              || (eng == mbrg_pkg::MBRG_ENG_START);
    // Two-tap pre-filter when shaping, else full deviation
    wire signed [2:0] next_step = bit_level(cur_bit) + (shaping_used ? bit_level(prev_bit)
                                                                    : bit_level(cur_bit));

    mbrg_fifo #(
        .WIDTH (BW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (wr_data[BW-1:0]),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (need_byte),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // AXI write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= mbrg_pkg::RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? mbrg_pkg::RESP_OKAY : mbrg_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= mbrg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_mapped ? mbrg_pkg::RESP_OKAY : mbrg_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= mbrg_pkg::CTRL_RST;
            div_high <= mbrg_pkg::DIV_HIGH_RST;
            div_low  <= mbrg_pkg::DIV_LOW_RST;
            frac     <= mbrg_pkg::FRAC_RST;
        end else if (do_write && lane0) begin
            if (wr_ctrl) ctrl <= new_ctrl;
            if (wr_high) div_high <= wr_data[BW-1:0];
            if (wr_low) div_low <= wr_data[BW-1:0];
            if (wr_frac) frac <= wr_data[FW-1:0];
        end
    end

    // Flag a shaping change until the transmitter restarts; set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) restart_needed <= 1'b0;
        else if (set_restart) restart_needed <= 1'b1;
        else if (clr_restart) restart_needed <= 1'b0;
    end

    // Transmit engine; shaping is latched only at start so a change needs a restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng          <= mbrg_pkg::MBRG_ENG_OFF;
            shaping_used <= 1'b0;
            tx_active    <= 1'b0;
            rx_active    <= 1'b0;
        end else begin
            case (eng)
                mbrg_pkg::MBRG_ENG_OFF: begin
                    if (want_tx) eng <= mbrg_pkg::MBRG_ENG_START;
                end
                mbrg_pkg::MBRG_ENG_START: begin
                    shaping_used <= ctrl.shaping;
                    eng          <= want_tx ? mbrg_pkg::MBRG_ENG_RUN : mbrg_pkg::MBRG_ENG_OFF;
                end
                mbrg_pkg::MBRG_ENG_RUN: begin
                    if (!want_tx) eng <= mbrg_pkg::MBRG_ENG_OFF;
                end
                default: eng <= mbrg_pkg::MBRG_ENG_OFF;
            endcase
            // Receive only while the transmit engine is off
            tx_active <= (eng == mbrg_pkg::MBRG_ENG_START) && want_tx
                      || (eng == mbrg_pkg::MBRG_ENG_RUN) && want_tx;
            rx_active <= (ctrl.op == mbrg_pkg::MBRG_OP_RX) && (eng == mbrg_pkg::MBRG_ENG_OFF)
                      && !tx_active;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            cnt <= '0;
            acc <= '0;
        end else if (cnt == '0) begin
            cnt <= reload;
            acc <= acc_sum[FW-1:0];
        end else begin
            cnt <= cnt - DW'(1);
        end
    end

    // Data pin synchroniser; no bit timing is applied in async mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_meta <= 1'b0;
            data_sync <= 1'b0;
        end else begin
            data_meta <= general_io_two;
            data_sync <= data_meta;
        end
    end

    // Bit clock rises at each bit start, falls at mid-bit
    always_ff @(posedge aclk) begin
        if (!aresetn || !(tx_on && gauss && want_tx)) bit_clock_out <= 1'b0;
        else if (tick) bit_clock_out <= 1'b1;
        else if (cnt == half_pt) bit_clock_out <= 1'b0;
    end

    // Bit source selection
    always_ff @(posedge aclk) begin
        if (!aresetn || !tx_on) begin
            cur_bit   <= 1'b0;
            prev_bit  <= 1'b0;
            shreg     <= '0;
            bits_left <= '0;
        end else if (async_tx) begin
            cur_bit  <= data_sync;
            prev_bit <= cur_bit;
        end else if (tick) begin
            prev_bit <= cur_bit;
            if (gauss) begin
                // Host placed this bit after the previous clock edge
                cur_bit <= data_sync;
            end else if (bits_left != '0) begin
                cur_bit   <= shreg[BW-1];
                shreg     <= {shreg[BW-2:0], 1'b0};
                bits_left <= bits_left - 4'h1;
            end else if (fifo_out_valid) begin
                cur_bit   <= fifo_out[BW-1];
                shreg     <= {fifo_out[BW-2:0], 1'b0};
                bits_left <= 4'(BW - 1);
            end else begin
                // Underrun sends zeros rather than stalling the air rate
                cur_bit <= 1'b0;
            end
        end
    end

    // Modulator drive: synthesizer step for FSK, PA gating for OOK
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_out <= '0;
        end else begin
            mod_out.bit_val <= cur_bit;
            mod_out.step    <= (tx_on && !ctrl.ook) ? next_step : 3'sh0;
            mod_out.pa_on   <= tx_on && (!ctrl.ook || cur_bit);
        end
    end
endmodule : mbrg_top
`default_nettype wire

// File: test/mbrg_host.sv
// Host-side model that drives the transmit data pin, freely or in step with the bit clock
`default_nettype none
module mbrg_host (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic bit_clock_out,
    input  wire logic sync_mode,
    input  wire logic async_bit,
    output logic      general_io_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_seen;
    logic       sync_pin;
    logic [7:0] pattern;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_seen <= 1'b0;
            sync_pin <= 1'b0;
            pattern  <= 8'h5c;
        end else begin
            clk_seen <= bit_clock_out;
            if (bit_clock_out && !clk_seen) begin
                sync_pin <= pattern[7];
                pattern  <= {pattern[6:0], pattern[7] ^ pattern[5]};
            end
        end
    end
    assign general_io_two = sync_mode ? sync_pin : async_bit;
endmodule : mbrg_host
`default_nettype wire

// File: test/mbrg_chk.sv
// Concurrent checks on the ports of the bit rate generator top
`default_nettype none
module mbrg_chk (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [mbrg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic [mbrg_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0]                  s_axi_wstrb,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [mbrg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [mbrg_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        general_io_two,
    input wire logic                        bit_clock_out,
    input wire mbrg_pkg::mbrg_mod_t         mod_out,
    input wire logic                        tx_active,
    input wire logic                        rx_active
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // TXDATA writes may stall on a full buffer, so they are left out
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr != mbrg_pkg::OFF_TXDATA;
    endsequence
    half_duplex_a: assert property (!(tx_active && rx_active))
        else $error("transmit and receive active together");
    clock_idle_a: assert property (!tx_active && !$past(tx_active) |-> !bit_clock_out)
        else $error("bit clock toggles outside transmit");
    bit_rise_a: assert property ($rose(bit_clock_out) |-> tx_active)
        else $error("bit clock rise without transmit");
    step_idle_a: assert property (!tx_active && !$past(tx_active) |-> mod_out.step == 3'b000)
        else $error("synthesizer step moves while idle");
    step_legal_a: assert property (tx_active |-> mod_out.step inside {3'b110, 3'b000, 3'b010})
        else $error("illegal synthesizer step");
    read_lat_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    write_ans_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    unmapped_rd_a: assert property (ar_taken ##0 s_axi_araddr > mbrg_pkg::OFF_STATUS
        |=> s_axi_rresp == mbrg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : mbrg_chk
bind mbrg_top mbrg_chk u_chk (.*);
`default_nettype wire

// File: test/tb_modem_bit_rate_generator.sv
// Self-checking bench for the bit rate generator, AXI4-Lite master and host model
`default_nettype none
module tb_modem_bit_rate_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        aclk = 1'b0, aresetn = 1'b0;
    logic [mbrg_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [mbrg_pkg::DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]                  s_axi_wstrb = 4'hf;
    logic                        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                        s_axi_arvalid = 0, s_axi_rready = 0, sync_mode = 0;
    logic                        async_bit = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                        s_axi_arready, s_axi_rvalid, general_io_two, bit_clock_out;
    logic                        tx_active, rx_active;
    logic [1:0]                  s_axi_bresp, s_axi_rresp;
    mbrg_pkg::mbrg_mod_t         mod_out;
    int                          n_fail = 0, n_tests = 0, i, j, n, f, c, shadow[6];
    int                          fq[$];
    bit                          hist[$];

    mbrg_top #(.FIFO_DEPTH(8)) u_dut (.*);
    mbrg_host u_host (.aclk, .aresetn, .bit_clock_out, .sync_mode, .async_bit, .general_io_two);

    always #25 aclk = ~aclk;

    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic hang();
        n_fail++;
        $display("[FAIL] %0t ns: wait ran out", $time);
        end_of_test();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > mbrg_pkg::OFF_STATUS) ? mbrg_pkg::RESP_SLVERR : mbrg_pkg::RESP_OKAY;
    endfunction : resp_of
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        bit ad = 0;
        bit wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 400; k++) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk(32'(s_axi_bresp), 32'(resp_of(a)));
                return;
            end
        end
        hang();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 400; k++) begin
            @(posedge aclk);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                v = s_axi_rdata;
                chk(32'(s_axi_rresp), 32'(resp_of(a)));
                return;
            end
        end
        hang();
    endtask : axi_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        axi_rd(a, v);
        chk(v & m, e & m);
    endtask : rd_chk
    task automatic set_rate(input int nn, input int ff);
        axi_wr(mbrg_pkg::OFF_DIV_HIGH, 32'(nn >> 8));
        axi_wr(mbrg_pkg::OFF_DIV_LOW, 32'(nn & 255));
        axi_wr(mbrg_pkg::OFF_FRAC, 32'(ff));
    endtask : set_rate
    // Sum of 16 bit periods, edge to edge of the bit clock
    task automatic meas(output int cyc);
        int  r = 0;
        logic p = bit_clock_out;
        cyc = 0;
        for (int k = 0; k < 3000 && r < 17; k++) begin
            @(posedge aclk);
            if (bit_clock_out && !p) r++;
            if (r > 0 && r < 17) cyc++;
            p = bit_clock_out;
        end
        if (r < 17) hang();
    endtask : meas

    initial begin
        void'($urandom(11119));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        shadow = '{0, mbrg_pkg::DIV_HIGH_RST, mbrg_pkg::DIV_LOW_RST, 0, 0, 4};
        for (i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h3f, 32'(shadow[i]));
        rd_chk(8'h18, 32'hffffffff, 32'h0);
        for (i = 0; i < 3; i++) begin
            for (j = 1; j < 4; j++) shadow[j] = $urandom();
            for (j = 1; j < 4; j++) axi_wr(8'(4 * j), 32'(shadow[j]));
            for (j = 1; j < 4; j++) rd_chk(8'(4 * j), (j == 3) ? 32'hf : 32'hff, 32'(shadow[j]));
        end
        // Fill the buffer while idle; the engine sends it MSB first, two cycles a bit
        set_rate(2, 0);
        for (i = 0; i < 8; i++) begin
            fq.push_back($urandom_range(255));
            axi_wr(mbrg_pkg::OFF_TXDATA, 32'(fq[$]));
        end
        rd_chk(mbrg_pkg::OFF_STATUS, 32'hf, (fq.size() == 8) ? 32'h8 : 32'h0);
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h01);
        repeat (4) @(posedge aclk);
        for (i = 0; i < 64; i++) begin
            chk(32'(mod_out.bit_val), 32'((fq[i / 8] >> (7 - i % 8)) & 1));
            repeat (2) @(posedge aclk);
        end
        chk(32'(tx_active), 32'h1);
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h00);
        // Continuous mode, no shaping: the pin reaches the modulator without a bit clock
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h05);
        for (i = 0; i < 20 && tx_active !== 1'b1; i++) @(posedge aclk);
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            hist.push_back(1'($urandom_range(1)));
            async_bit <= hist[$];
            chk(32'(bit_clock_out), 32'h0);
            if (i >= 5) chk(32'(mod_out.bit_val), 32'(hist[$-5]));
        end
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h00);
        n = $urandom_range(9, 2);
        f = $urandom_range(15, 1);
        set_rate(n, f);
        @(posedge aclk);
        sync_mode <= 1'b1;
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h15);
        meas(c);
        chk(32'(c), 32'(16 * n + f));
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h05);
        rd_chk(mbrg_pkg::OFF_STATUS, 32'h10, 32'h10);
        axi_wr(mbrg_pkg::OFF_STATUS, 32'h10);
        rd_chk(mbrg_pkg::OFF_STATUS, 32'h10, 32'h00);
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h00);
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h1d);
        meas(c);
        chk(32'(c), 32'(16 * n));
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h00);
        axi_wr(mbrg_pkg::OFF_CTRL, 32'h02);
        repeat (3) @(posedge aclk);
        chk(32'({rx_active, tx_active}), 32'h2);
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge aclk);
        hang();
    end
endmodule : tb_modem_bit_rate_generator
`default_nettype wire
